// [design/eridec_top.sv]
// External register decode and hardware registers 70-7F
`timescale 1ns/1ns
module eridec_top
   import eridec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic io_valid,
   input wire logic io_write,
   input wire logic [6:0] io_addr,
   input wire logic [23:0] io_wdata,
   output logic [23:0] io_rdata,
   output logic io_rvalid,
   input wire logic [2:0] current_level,
   input wire logic level1_entry,
   input wire logic [3:0] interrupted_level,
   input wire logic level1_exit,
   input wire logic carry5,
   input wire logic zero5,
   input wire logic instr_done,
   input wire logic [23:0] instr_addr,
   input wire logic adapter_error_stop,
   input wire logic [4:0] channel_command_word,
   input wire logic [7:0] storage_size,
   input wire logic [23:0] operator_entry,
   input wire logic [15:0] operator_select,
   input wire logic [7:0] channel_req_set,
   input wire logic [7:0] adapter_req_set,
   input wire logic [7:0] hard_errors,
   input wire logic [23:0] trace_pointer,
   input wire logic [23:0] trace_count,
   input wire logic [4:0] int_ack,
   input wire logic hard_stop_clear,
   input wire logic cpu_busy,
   output logic hard_stop,
   output logic exec_enable,
   output logic cycle_steal_enable,
   output logic level5_run_enable,
   output logic [4:0] interrupt_request,
   output logic [23:0] display_register_one,
   output logic [23:0] display_register_two,
   output logic [7:0] protect_exception_key,
   output logic high_speed_buffer_on,
   output logic storage_controller_ecc_on,
   output logic alu_check_force,
   output logic initial_load_request,
   output logic remote_power_off
);
   // Decoded strobes
   logic wr; // Output instruction this cycle
   logic rd; // Input instruction this cycle
   logic invalid_op; // Unused location touched
   logic addr_unused; // From the range checker
   // Stored registers and derived signals
   logic [7:0] key_mem [16]; // Protect key storage
   logic [3:0] key_sel; // Key picked by last write
   logic [23:0] lagging_address; // Last finished instruction
   logic [5:0] cmd_cap; // Captured command bits, valid flag on top
   logic [7:0] ch_req; // Level 1 request latches
   logic [7:0] ad_req; // Adapter request latches
   logic [3:0] prev_level; // Level before level 1 entry
   logic [2:0] pci; // Soft requests for levels 2-4
   logic [4:0] mask; // Level mask bits
   logic [4:0] pending; // Raw per-level requests
   logic [23:0] timer; // High resolution timer
   logic [23:0] usage; // Utilization counter
   logic tmr_run; // Timer counting
   logic use_run; // Counter counting
   logic [6:0] tick_cnt; // Tick divider
   logic tick; // One pulse per tick period
   logic [23:0] next_rdata; // Read mux
   // Strobe decode
   assign wr = io_valid && io_write;
   assign rd = io_valid && !io_write;
   assign invalid_op = io_valid && addr_unused;
   // Unused range checker
   eridec_addr_check eridec_addr_check_inst (
      .addr(io_addr),
      .is_write(io_write),
      .unused(addr_unused)
   );
   // Hard stop: entered by write 70, left by maintenance clear
   always_ff @(posedge clock) begin
      if (rst) begin
         hard_stop <= 1'b0;
      end else if (wr && io_addr == ADR_HALT) begin
         hard_stop <= 1'b1;
      end else if (hard_stop_clear) begin
         hard_stop <= 1'b0;
      end
   end
   // Stop blocks execution and cycle steals; interrupt requests are not gated by it
   assign exec_enable = !hard_stop;
   assign cycle_steal_enable = !hard_stop;
   // Level 5 runs only while unmasked and not stopped
   assign level5_run_enable = !hard_stop && !mask[4];
   // Display registers take whole 24-bit words
   always_ff @(posedge clock) begin
      if (rst) begin
         display_register_one <= RST_WORD;
         display_register_two <= RST_WORD;
      end else if (wr && io_addr == ADR_DISP1) begin
         display_register_one <= io_wdata;
      end else if (wr && io_addr == ADR_DISP2) begin
         display_register_two <= io_wdata;
      end
   end
   // Key select and optional key set
   always_ff @(posedge clock) begin
      if (rst) begin
         key_sel <= RST_KEY;
      end else if (wr && io_addr == ADR_KEY) begin
         key_sel <= io_wdata[KEY_IDX_LSB +: 4];
      end
   end
   // Key storage; no reset, contents set by software
   always_ff @(posedge clock) begin
      if (wr && io_addr == ADR_KEY && io_wdata[KEY_SET_BIT]) begin
         key_mem[io_wdata[KEY_IDX_LSB +: 4]] <= io_wdata[KEY_VAL_LSB +: 8];
      end
   end
   // Selected key drives storage protection
   assign protect_exception_key = key_mem[key_sel];
   // Buffer and ECC operating state
   always_ff @(posedge clock) begin
      if (rst) begin
         high_speed_buffer_on <= 1'b0;
         storage_controller_ecc_on <= 1'b0;
      end else if (wr && io_addr == ADR_LAG) begin
         high_speed_buffer_on <= io_wdata[SC_BUF_BIT];
         storage_controller_ecc_on <= io_wdata[SC_ECC_BIT];
      end
   end
   // Lagging address follows each finished instruction
   always_ff @(posedge clock) begin
      if (rst) begin
         lagging_address <= RST_WORD;
      end else if (instr_done) begin
         lagging_address <= instr_addr;
      end
   end
   // Command capture on error stop; no write path
   always_ff @(posedge clock) begin
      if (rst) begin
         cmd_cap <= 6'h00;
      end else if (adapter_error_stop) begin
         cmd_cap <= {1'b1, channel_command_word};
      end
   end
   // Level 1 and adapter request latches; hardware set wins
   always_ff @(posedge clock) begin
      if (rst) begin
         ch_req <= 8'h00;
         ad_req <= 8'h00;
      end else begin
         // Write 76 bits 15:8 reset, bits 7:0 set level 1 latches
         if (wr && io_addr == ADR_CHREQ) begin
            ch_req <= ((ch_req & ~io_wdata[15:8]) | io_wdata[7:0]) | channel_req_set;
         end else begin
            ch_req <= ch_req | channel_req_set;
         end
         // Invalid operation raises its level 1 bit
         if (invalid_op) begin
            ch_req[L1_INVOP_BIT] <= 1'b1;
         end
         // Write 77 bits 15:8 reset, bits 7:0 set adapter latches
         if (wr && io_addr == ADR_ADREQ) begin
            ad_req <= ((ad_req & ~io_wdata[15:8]) | io_wdata[7:0]) | adapter_req_set;
         end else begin
            ad_req <= ad_req | adapter_req_set;
         end
      end
   end
   // Diagnostic compare check pulse
   always_ff @(posedge clock) begin
      if (rst) begin
         alu_check_force <= 1'b0;
      end else begin
         alu_check_force <= wr && io_addr == ADR_ALUCHK;
      end
   end
   // Utility latches: load request pulse, power off level
   always_ff @(posedge clock) begin
      if (rst) begin
         initial_load_request <= 1'b0;
         remote_power_off <= 1'b0;
      end else begin
         // Load request does not touch hard stop
         initial_load_request <= wr && io_addr == ADR_UTIL && io_wdata[UTIL_LOAD_BIT];
         if (wr && io_addr == ADR_UTIL) begin
            remote_power_off <= io_wdata[UTIL_RPO_BIT];
         end
      end
   end
   // Interrupted level, kept only while in level 1
   always_ff @(posedge clock) begin
      if (rst) begin
         prev_level <= 4'h0;
      end else if (level1_entry) begin
         prev_level <= interrupted_level;
      end else if (level1_exit) begin
         prev_level <= 4'h0;
      end
   end
   // Tick divider for the timer
   always_ff @(posedge clock) begin
      if (rst) begin
         tick_cnt <= 7'h00;
      end else if (tick) begin
         tick_cnt <= 7'h00;
      end else begin
         tick_cnt <= tick_cnt + 7'h01;
      end
   end
   assign tick = tick_cnt == 7'(TICK_CYC - 1);
   // Timer and utilization counter control
   always_ff @(posedge clock) begin
      if (rst) begin
         tmr_run <= 1'b0;
         use_run <= 1'b0;
         timer <= RST_WORD;
         usage <= RST_WORD;
      end else if (wr && io_addr == ADR_TIMER) begin
         tmr_run <= io_wdata[TMR_RUN_BIT];
         use_run <= io_wdata[USE_RUN_BIT];
         timer <= RST_WORD;
         usage <= RST_WORD;
      end else if (tick) begin
         if (tmr_run) begin
            timer <= timer + 24'h000001;
         end
         if (use_run && cpu_busy) begin
            usage <= usage + 24'h000001;
         end
      end
   end
   // Soft interrupts 2-4, set wins over acknowledge
   always_ff @(posedge clock) begin
      if (rst) begin
         pci <= 3'h0;
      end else begin
         pci <= (pci & ~int_ack[3:1]) | {wr && io_addr == ADR_PCI4,
                                         wr && io_addr == ADR_PCI3,
                                         wr && io_addr == ADR_PCI2};
      end
   end
   // Raw requests per level, level 1 at index 0
   assign pending = {1'b0,
                     pci[2] | ad_req[2],
                     pci[1] | ad_req[1],
                     pci[0] | ad_req[0],
                     (|ch_req) | (|hard_errors)};
   // Mask bits and gated requests
   eridec_level_bank eridec_level_bank_inst (
      .clock(clock),
      .rst(rst),
      .mask_set(wr && io_addr == ADR_MSET),
      .mask_reset(wr && io_addr == ADR_MRST),
      .mask_data(io_wdata[MASK_LSB +: 5]),
      .pending(pending),
      .mask(mask),
      .request(interrupt_request)
   );
   // Read multiplexer for locations 70-7F
   always_comb begin
      next_rdata = RST_WORD;
      case (io_addr)
         ADR_HALT: begin
            next_rdata[15:8] = storage_size;
         end
         ADR_DISP1: begin
            next_rdata = operator_entry;
         end
         ADR_DISP2: begin
            next_rdata[15:0] = operator_select;
         end
         ADR_KEY: begin
            next_rdata[KEY_VAL_LSB +: 8] = key_mem[key_sel];
         end
         ADR_LAG: begin
            next_rdata = lagging_address;
         end
         ADR_CMD: begin
            next_rdata[4:0] = cmd_cap[4:0];
            next_rdata[CMD_VALID_BIT] = cmd_cap[5];
         end
         ADR_CHREQ: begin
            next_rdata[7:0] = ch_req;
         end
         ADR_ADREQ: begin
            next_rdata[7:0] = ad_req;
         end
         ADR_UTIL: begin
            next_rdata[UTIL_C_BIT] = carry5;
            next_rdata[UTIL_Z_BIT] = zero5;
            next_rdata[UTIL_RPO_BIT] = remote_power_off;
            if (current_level == 3'h1) begin
               next_rdata[UTIL_PRV_LSB +: 4] = prev_level;
            end
         end
         ADR_TIMER: begin
            next_rdata = timer;
         end
         ADR_PCI2: begin
            next_rdata = trace_pointer;
         end
         ADR_PCI3: begin
            next_rdata = trace_count;
         end
         ADR_PCI4: begin
            next_rdata[7:0] = hard_errors;
         end
         ADR_MSET: begin
            next_rdata[7:0] = ch_req;
            next_rdata[L1_HARD_SUM_BIT] = |hard_errors;
         end
         ADR_MRST: begin
            next_rdata[2:0] = pci | ad_req[2:0];
         end
         default: begin
            next_rdata = RST_WORD;
         end
      endcase
   end
   // Read data registered one cycle after the request
   always_ff @(posedge clock) begin
      if (rst) begin
         io_rdata <= RST_WORD;
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= rd;
         if (rd) begin
            io_rdata <= next_rdata;
         end
      end
   end
   // Location 75 has no write decode at all, so writes there are inert
endmodule

// [design/eridec_pkg.sv]
// Constants for the external register decode block
package eridec_pkg;
   // Data and address widths
   localparam int DATA_W = 24;
   localparam int ADDR_W = 7;
   localparam int LEVELS = 5;
   // Hardware register locations
   localparam logic [6:0] ADR_HALT = 7'h70;
   localparam logic [6:0] ADR_DISP1 = 7'h71;
   localparam logic [6:0] ADR_DISP2 = 7'h72;
   localparam logic [6:0] ADR_KEY = 7'h73;
   localparam logic [6:0] ADR_LAG = 7'h74;
   localparam logic [6:0] ADR_CMD = 7'h75;
   localparam logic [6:0] ADR_CHREQ = 7'h76;
   localparam logic [6:0] ADR_ADREQ = 7'h77;
   localparam logic [6:0] ADR_ALUCHK = 7'h78;
   localparam logic [6:0] ADR_UTIL = 7'h79;
   localparam logic [6:0] ADR_TIMER = 7'h7A;
   localparam logic [6:0] ADR_PCI2 = 7'h7B;
   localparam logic [6:0] ADR_PCI3 = 7'h7C;
   localparam logic [6:0] ADR_PCI4 = 7'h7D;
   localparam logic [6:0] ADR_MSET = 7'h7E;
   localparam logic [6:0] ADR_MRST = 7'h7F;
   // Unused ranges, low and high bound
   localparam logic [6:0] UNUSED_A_LO = 7'h28;
   localparam logic [6:0] UNUSED_A_HI = 7'h2F;
   localparam logic [6:0] UNUSED_B_LO = 7'h38;
   localparam logic [6:0] UNUSED_B_HI = 7'h3E;
   localparam logic [6:0] UNUSED_C_LO = 7'h49;
   localparam logic [6:0] UNUSED_C_HI = 7'h4F;
   localparam logic [6:0] UNUSED_D_LO = 7'h6C;
   localparam logic [6:0] UNUSED_D_HI = 7'h6E;
   // Field positions (vector index; byte X bit 0 is index 23)
   localparam int UTIL_LOAD_BIT = 13;
   localparam int UTIL_RPO_BIT = 11;
   localparam int UTIL_C_BIT = 9;
   localparam int UTIL_Z_BIT = 8;
   localparam int UTIL_PRV_LSB = 4;
   localparam int SC_BUF_BIT = 15;
   localparam int SC_ECC_BIT = 14;
   localparam int KEY_SET_BIT = 23;
   localparam int KEY_IDX_LSB = 0;
   localparam int KEY_VAL_LSB = 8;
   localparam int TMR_RUN_BIT = 15;
   localparam int USE_RUN_BIT = 14;
   localparam int MASK_LSB = 11;
   localparam int L1_INVOP_BIT = 0;
   localparam int L1_HARD_SUM_BIT = 8;
   localparam int CMD_VALID_BIT = 23;
   // Reset values
   localparam logic [23:0] RST_WORD = 24'h000000;
   localparam logic [4:0] RST_MASK = 5'h00;
   localparam logic [3:0] RST_KEY = 4'h0;
   // Timer tick period
   localparam int TICK_NS = 1000;
   localparam int CLK_NS = 10;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
endpackage

// [design/eridec_addr_check.sv]
// Unused location detector for input and output instructions
`timescale 1ns/1ns
module eridec_addr_check
   import eridec_pkg::*;
(
   input wire logic [6:0] addr,
   input wire logic is_write,
   output logic unused
);
   // Range hit helper
   function automatic logic in_rng(input logic [6:0] a, input logic [6:0] lo, input logic [6:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   // Ranges common to both directions, 78 only for reads
   always_comb begin
      unused = in_rng(addr, UNUSED_A_LO, UNUSED_A_HI)
            || in_rng(addr, UNUSED_B_LO, UNUSED_B_HI)
            || in_rng(addr, UNUSED_C_LO, UNUSED_C_HI)
            || in_rng(addr, UNUSED_D_LO, UNUSED_D_HI)
            || (!is_write && addr == ADR_ALUCHK);
   end
endmodule

// [design/eridec_level_bank.sv]
// Per-level mask bits and gated interrupt requests
`timescale 1ns/1ns
module eridec_level_bank
   import eridec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic mask_set,
   input wire logic mask_reset,
   input wire logic [4:0] mask_data,
   input wire logic [4:0] pending,
   output logic [4:0] mask,
   output logic [4:0] request
);
   // One mask latch per program level
   genvar g;
   generate
      for (g = 0; g < LEVELS; g++) begin : lvl
         logic bit_q; // This level's mask latch
         // Set by ones on set-write, cleared by ones on reset-write
         always_ff @(posedge clock) begin
            if (rst) begin
               bit_q <= RST_MASK[g];
            end else if (mask_set && mask_data[g]) begin
               bit_q <= 1'b1;
            end else if (mask_reset && mask_data[g]) begin
               bit_q <= 1'b0;
            end
         end
         // One driver per mask bit
         assign mask[g] = bit_q;
         // Masked levels ignore requests; unmasked pending shows at once
         assign request[g] = pending[g] && !mask[g];
      end
   endgenerate
endmodule

// [tb/eridec_props.sv]
// Property checker for the external register decode block
`timescale 1ns/1ns
module eridec_props
   import eridec_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic io_valid,
   input wire logic io_write,
   input wire logic [6:0] io_addr,
   input wire logic [23:0] io_wdata,
   input wire logic [23:0] io_rdata,
   input wire logic io_rvalid,
   input wire logic carry5,
   input wire logic zero5,
   input wire logic instr_done,
   input wire logic [23:0] instr_addr,
   input wire logic hard_stop,
   input wire logic exec_enable,
   input wire logic cycle_steal_enable,
   input wire logic level5_run_enable,
   input wire logic [4:0] interrupt_request,
   input wire logic [23:0] display_register_one,
   input wire logic alu_check_force,
   input wire logic initial_load_request
);
   // Access qualifiers
   wire rd = io_valid && !io_write;
   wire wr = io_valid && io_write;
   wire bad = io_addr inside {[UNUSED_A_LO:UNUSED_A_HI], [UNUSED_B_LO:UNUSED_B_HI],
                              [UNUSED_C_LO:UNUSED_C_HI], [UNUSED_D_LO:UNUSED_D_HI]};
   logic [4:0] m; // Expected mask bits
   logic [23:0] lag_q; // Address of last finished instruction
   // Mask shadow, set by 7E and cleared by 7F
   always_ff @(posedge clock) begin
      if (rst) m <= RST_MASK;
      else if (wr && io_addr == ADR_MSET) m <= m | io_wdata[MASK_LSB +: 5];
      else if (wr && io_addr == ADR_MRST) m <= m & ~io_wdata[MASK_LSB +: 5];
   end
   // Lagging address shadow
   always_ff @(posedge clock) begin
      if (rst) lag_q <= RST_WORD;
      else if (instr_done) lag_q <= instr_addr;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // One-cycle strobe shape
   sequence s_pulse(s);
      s ##1 !s;
   endsequence
   property p_rd_ans; rd |=> io_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_inv_rd; rd && (bad || io_addr == ADR_ALUCHK) && !m[0] |=> interrupt_request[0] && io_rdata == RST_WORD;
   endproperty
   a_inv_rd: assert property (p_inv_rd) else $error("unused read not flagged");
   property p_inv_wr; wr && bad && !m[0] |=> interrupt_request[0]; endproperty
   a_inv_wr: assert property (p_inv_wr) else $error("unused write not flagged");
   property p_halt; wr && io_addr == ADR_HALT |=> hard_stop && !exec_enable && !cycle_steal_enable; endproperty
   a_halt: assert property (p_halt) else $error("hard stop not entered");
   property p_disp; wr && io_addr == ADR_DISP1 |=> display_register_one == $past(io_wdata); endproperty
   a_disp: assert property (p_disp) else $error("display one not loaded");
   property p_alu; wr && io_addr == ADR_ALUCHK |=> s_pulse(alu_check_force); endproperty
   a_alu: assert property (p_alu) else $error("alu check pulse wrong");
   property p_ipl; wr && io_addr == ADR_UTIL && io_wdata[UTIL_LOAD_BIT] |=> !hard_stop ##0 s_pulse(initial_load_request);
   endproperty
   a_ipl: assert property (p_ipl) else $error("load request wrong");
   property p_cz; rd && io_addr == ADR_UTIL |=> io_rdata[UTIL_C_BIT] == $past(carry5) && io_rdata[UTIL_Z_BIT] == $past(zero5);
   endproperty
   a_cz: assert property (p_cz) else $error("level 5 condition bits wrong");
   property p_lag; rd && io_addr == ADR_LAG && !instr_done |=> io_rdata == $past(lag_q); endproperty
   a_lag: assert property (p_lag) else $error("lagging address wrong");
   property p_l5; m[4] |-> !level5_run_enable; endproperty
   a_l5: assert property (p_l5) else $error("level 5 runs while masked");
   property p_mask; m[1] |-> !interrupt_request[1]; endproperty
   a_mask: assert property (p_mask) else $error("masked request seen");
endmodule
bind eridec_top eridec_props eridec_props_inst (.*);

// [tb/tb.sv]
// Self-checking bench for the external register decode block
`timescale 1ns/1ns
module tb
   import eridec_pkg::*;
;
   // Design inputs
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic io_valid = 1'b0, io_write = 1'b0, level1_entry = 1'b0, level1_exit = 1'b0, carry5 = 1'b0, zero5 = 1'b0;
   logic instr_done = 1'b0, adapter_error_stop = 1'b0, hard_stop_clear = 1'b0, cpu_busy = 1'b0;
   logic [6:0] io_addr = 7'h00;
   logic [23:0] io_wdata = 24'h000000, instr_addr = 24'h000000, operator_entry = 24'h000000;
   logic [23:0] trace_pointer = 24'h000000, trace_count = 24'h000000;
   logic [2:0] current_level = 3'h5;
   logic [3:0] interrupted_level = 4'h0;
   logic [4:0] channel_command_word = 5'h00, int_ack = 5'h00;
   logic [7:0] storage_size = 8'h00, channel_req_set = 8'h00, adapter_req_set = 8'h00, hard_errors = 8'h00;
   logic [15:0] operator_select = 16'h0000;
   // Design outputs
   logic [23:0] io_rdata, display_register_one, display_register_two;
   logic io_rvalid, hard_stop, exec_enable, cycle_steal_enable, level5_run_enable, high_speed_buffer_on;
   logic storage_controller_ecc_on, alu_check_force, initial_load_request, remote_power_off;
   logic [4:0] interrupt_request;
   logic [7:0] protect_exception_key;
   int n_errors = 0;
   int n_checks = 0;
   eridec_top eridec_top_inst (.*);
   // 100 MHz clock
   initial begin
      forever #5 clock = ~clock;
   end
   // Verdict and end of run
   task automatic close_out();
      if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Compare and count
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Let n edges pass, settle after the last
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One instruction, taken at the next edge
   task automatic acc(input logic w, input logic [6:0] a, input logic [23:0] d);
      cyc(1);
      io_valid = 1'b1;
      io_write = w;
      io_addr = a;
      io_wdata = d;
      cyc(1);
      io_valid = 1'b0;
   endtask
   // Input instruction with masked compare
   task automatic rd(input logic [6:0] a, input logic [23:0] exp, input logic [23:0] msk);
      acc(1'b0, a, 24'h000000);
      cmp(24'(io_rvalid), 24'h000001);
      cmp(io_rdata & msk, exp);
   endtask
   // Unused locations in both directions, then write 78
   task automatic s_unused();
      logic [6:0] ua [9];
      ua = '{7'h28, 7'h2F, 7'h38, 7'h3E, 7'h49, 7'h4F, 7'h6C, 7'h6E, ADR_ALUCHK};
      for (int i = 0; i < 18; i++) begin
         if (i < 17) begin
            acc(i[0], ua[i / 2], 24'hFFFFFF);
            cmp(24'(interrupt_request[0]), 24'h000001);
            acc(1'b1, ADR_CHREQ, 24'h000100);
            cmp(24'(interrupt_request[0]), 24'h000000);
         end
      end
      acc(1'b1, ADR_ALUCHK, 24'h000000);
      cmp({alu_check_force, interrupt_request[0]}, 2'b10);
   endtask
   // Display, key, storage control, dead write to 75
   task automatic s_regs();
      acc(1'b1, ADR_DISP1, 24'hA5C3E1);
      cmp(display_register_one, 24'hA5C3E1);
      acc(1'b1, ADR_DISP2, 24'h5A3C1E);
      cmp(display_register_two, 24'h5A3C1E);
      acc(1'b1, ADR_KEY, 24'h80A502);
      acc(1'b1, ADR_KEY, 24'h803C05);
      acc(1'b1, ADR_KEY, 24'h000002);
      cmp(protect_exception_key, 8'hA5);
      acc(1'b1, ADR_KEY, 24'h00FF05);
      cmp(protect_exception_key, 8'h3C);
      rd(ADR_KEY, 24'h003C00, 24'hFFFFFF);
      acc(1'b1, ADR_LAG, 24'h008000);
      cmp({high_speed_buffer_on, storage_controller_ecc_on}, 2'b10);
      acc(1'b1, ADR_LAG, 24'h004000);
      cmp({high_speed_buffer_on, storage_controller_ecc_on}, 2'b01);
      acc(1'b1, ADR_CMD, 24'hFFFFFF);
      cmp({display_register_one, hard_stop, storage_controller_ecc_on, interrupt_request}, {24'hA5C3E1, 7'h20});
   endtask
   // Lagging address, captured command bits, read-back words
   task automatic s_capture();
      cyc(1);
      instr_done = 1'b1;
      instr_addr = 24'h123456;
      cyc(1);
      instr_addr = 24'h00ABCD;
      cyc(1);
      instr_done = 1'b0;
      rd(ADR_LAG, 24'h00ABCD, 24'hFFFFFF);
      channel_command_word = 5'h15;
      adapter_error_stop = 1'b1;
      cyc(1);
      adapter_error_stop = 1'b0;
      rd(ADR_CMD, 24'h800015, 24'h80001F);
      storage_size = 8'hC1;
      operator_entry = 24'h6B2D91;
      operator_select = 16'h4E07;
      trace_pointer = 24'h31F0A8;
      trace_count = 24'h0C5E3B;
      rd(ADR_HALT, 24'h00C100, 24'hFFFFFF);
      rd(ADR_DISP1, 24'h6B2D91, 24'hFFFFFF);
      rd(ADR_DISP2, 24'h004E07, 24'hFFFFFF);
      rd(ADR_PCI2, 24'h31F0A8, 24'hFFFFFF);
      rd(ADR_PCI3, 24'h0C5E3B, 24'hFFFFFF);
      // Timer run: 200 edges between clear and read give two ticks
      acc(1'b1, ADR_TIMER, 24'h008000);
      cyc(199);
      rd(ADR_TIMER, 24'h000002, 24'hFFFFFF);
      acc(1'b1, ADR_TIMER, 24'h000000);
      rd(ADR_TIMER, 24'h000000, 24'hFFFFFF);
   endtask
   // Utility reads across levels, utility writes
   task automatic s_util();
      current_level = 3'h1;
      interrupted_level = 4'h3;
      carry5 = 1'b1;
      level1_entry = 1'b1;
      cyc(1);
      level1_entry = 1'b0;
      rd(ADR_UTIL, 24'h000230, 24'h0003F0);
      level1_exit = 1'b1;
      cyc(1);
      level1_exit = 1'b0;
      carry5 = 1'b0;
      zero5 = 1'b1;
      rd(ADR_UTIL, 24'h000100, 24'h0003F0);
      current_level = 3'h2;
      interrupted_level = 4'h4;
      level1_entry = 1'b1;
      cyc(1);
      level1_entry = 1'b0;
      rd(ADR_UTIL, 24'h000100, 24'h0003F0);
      acc(1'b1, ADR_UTIL, 24'h000800);
      cmp(24'(remote_power_off), 24'h000001);
      acc(1'b1, ADR_UTIL, 24'h002000);
      cmp({initial_load_request, hard_stop}, 2'b10);
      cyc(1);
      cmp(24'(initial_load_request), 24'h000000);
   endtask
   // Soft interrupts, masks, level 1 requests
   task automatic s_levels();
      for (int lv = 0; lv < 3; lv++) begin
         acc(1'b1, 7'(ADR_PCI2 + lv), 24'hFFFFFF);
         cmp(24'(interrupt_request[lv + 1]), 24'h000001);
      end
      rd(ADR_MRST, 24'h000007, 24'h000007);
      acc(1'b1, ADR_MSET, 24'h001000);
      cmp(interrupt_request, 5'h0C);
      acc(1'b1, ADR_MRST, 24'h001000);
      cmp(interrupt_request, 5'h0E);
      int_ack = 5'h0E;
      cyc(1);
      int_ack = 5'h00;
      cmp(interrupt_request, 5'h00);
      acc(1'b1, ADR_MSET, 24'h008000);
      cmp(24'(level5_run_enable), 24'h000000);
      acc(1'b1, ADR_MRST, 24'h008000);
      cmp(24'(level5_run_enable), 24'h000001);
      acc(1'b1, ADR_CHREQ, 24'h000004);
      hard_errors = 8'h10;
      rd(ADR_MSET, 24'h000104, 24'h0001FF);
      hard_errors = 8'h00;
      acc(1'b1, ADR_CHREQ, 24'h000400);
      cmp(interrupt_request, 5'h00);
      // Adapter latch for level 3, set by hardware, reset by write 77
      adapter_req_set = 8'h02;
      cyc(1);
      adapter_req_set = 8'h00;
      rd(ADR_ADREQ, 24'h000002, 24'hFFFFFF);
      cmp(interrupt_request, 5'h04);
      acc(1'b1, ADR_ADREQ, 24'h000200);
      cmp(interrupt_request, 5'h00);
   endtask
   // Hard stop entry and release
   task automatic s_halt();
      acc(1'b1, ADR_HALT, 24'hFFFFFF);
      cmp({hard_stop, exec_enable, cycle_steal_enable, level5_run_enable}, 4'h8);
      hard_stop_clear = 1'b1;
      cyc(1);
      hard_stop_clear = 1'b0;
      cmp({hard_stop, exec_enable, cycle_steal_enable}, 3'h3);
   endtask
   // Main sequence
   initial begin
      cyc(5);
      rst = 1'b0;
      s_unused();
      s_regs();
      s_capture();
      s_util();
      s_levels();
      s_halt();
      close_out();
   end
   // Hang guard
   initial begin
      #100000;
      n_errors++;
      close_out();
   end
endmodule
